// >>> pkg/nand_otp_ecc_pkg.sv
// constants shared by the otp and correction control block
package nand_otp_ecc_pkg;

   // =========================================================
   // apb register map
   localparam int unsigned APB_AW      = 12;
   localparam logic [11:0] FEAT_OFF    = 12'h000;
   localparam logic [11:0] STAT_OFF    = 12'h004;
   localparam logic [11:0] INFO_OFF    = 12'h008;
   localparam logic [11:0] CTRL_OFF    = 12'h00c;
   localparam logic [11:0] GEOM_OFF    = 12'h010;

   // =========================================================
   // feature byte layout and reset values
   localparam logic [7:0]  FEAT_ADDR_OTP = 8'hb0;
   localparam int unsigned FEAT_ECC_BIT  = 4;
   localparam int unsigned FEAT_EN_BIT   = 6;
   localparam int unsigned FEAT_LOCK_BIT = 7;
   localparam logic        ECC_EN_RST    = 1'b1;
   localparam logic        OTP_EN_RST    = 1'b0;
   localparam logic        LOCK_RST      = 1'b0;
   localparam logic        LINK_EN_RST   = 1'b1;

   // =========================================================
   // status field layout
   localparam int unsigned STAT_WEL_BIT  = 4;
   localparam int unsigned STAT_FAIL_BIT = 5;
   localparam int unsigned STAT_LOCK_BIT = 6;
   localparam int unsigned STAT_PAGE_LSB = 8;

   // =========================================================
   // serial opcodes
   localparam logic [7:0] OP_WREN      = 8'h06;
   localparam logic [7:0] OP_WRDI      = 8'h04;
   localparam logic [7:0] OP_SET_FEAT  = 8'h1f;
   localparam logic [7:0] OP_PROG_LOAD = 8'h02;
   localparam logic [7:0] OP_LOAD_RAND = 8'h84;
   localparam logic [7:0] OP_PROG_EXEC = 8'h10;
   localparam logic [7:0] OP_PAGE_READ = 8'h13;
   localparam logic [7:0] OP_RESET     = 8'hff;

   // =========================================================
   // array geometry
   localparam logic [2:0]  OTP_PAGES     = 3'h4;
   localparam logic [11:0] PAGE_BYTES    = 12'h880;
   localparam logic [10:0] TOTAL_BLOCKS  = 11'h400;
   localparam logic [10:0] MIN_VALID     = 11'h3ec;
   localparam logic [11:0] BAD_MARK_COL  = 12'h800;
   localparam logic [7:0]  BAD_MARK      = 8'h00;

   // =========================================================
   // correction coverage within a page
   localparam logic [11:0] MAIN_END      = 12'h7ff;
   localparam logic [11:0] META_START    = 12'h800;
   localparam logic [11:0] META_END      = 12'h83f;
   localparam logic [11:0] PARITY_START  = 12'h840;
   localparam logic [11:0] PARITY_END    = 12'h873;
   localparam logic [11:0] SPARE_END     = 12'h87f;
   localparam logic [3:0]  ECC_MAX_BITS  = 4'h8;
   localparam logic [3:0]  ECC_NONE      = 4'h0;
   localparam logic [3:0]  ECC_UNCORR    = 4'hf;

endpackage

// >>> verilog/nand_otp_ecc_ctrl.sv
// otp region and internal correction control of a serial nand device
//
// Behaviour
// - four good otp pages of 2176 bytes
// - otp lock bit starts at zero
// - otp uses program load, execute, page read
// - after lock, otp refuses all programming
// - lock stays one forever once burned
// - locked at power-on: otp read only
// - at least 1004 of 1024 blocks valid
// - bad blocks marked 00h at byte 2048
// - correction follows the enable feature bit
// - correction on after power-up
// - program computes code over cached page
// - read recomputes, corrects, outputs corrected data
// - each read updates correction status
// - parity byte writes ignored while correcting
// - bytes 000h-7ffh protected as four sectors
// - spare 800h-83fh protected metadata
// - parity at 840h-873h, tail unprotected
// - uncorrectable read reports status 1111b
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps

module nand_otp_ecc_ctrl
   import nand_otp_ecc_pkg::*;
#(
   parameter int unsigned ROW_W = 24
)
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              sclk,
   input  wire logic              cs_n,
   input  wire logic              mosi,
   input  wire logic              otp_lock_nv,
   input  wire logic              ecc_done,
   input  wire logic [3:0]        ecc_err_bits,
   input  wire logic              ecc_uncorrectable,
   output logic                   array_read,
   output logic                   array_program,
   output logic                   array_otp_sel,
   output logic      [ROW_W-1:0]  array_row,
   output logic                   ecc_encode,
   output logic                   ecc_decode,
   output logic                   otp_lock_burn,
   output logic                   load_valid,
   output logic      [11:0]       load_col,
   output logic      [7:0]        load_data,
   output logic                   load_protected
);

   if (ROW_W < 3 || ROW_W > 24)
   begin : g_bad_row_w
      $error("ROW_W must lie between 3 and 24");
   end

   // =========================================================
   // page column decoding
   function automatic logic is_parity(input logic [11:0] col);
      is_parity = (col >= PARITY_START) && (col <= PARITY_END);
   endfunction

   function automatic logic is_covered(input logic [11:0] col);
      is_covered = (col <= MAIN_END) ||
                   ((col >= META_START) && (col <= META_END)) ||
                   is_parity(col);
   endfunction

   // =========================================================
   // link input synchronisers
   logic [2:0]       sclk_q;
   logic [1:0]       cs_q;
   logic [1:0]       mosi_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sclk_q <= 3'h0;
         cs_q   <= 2'h3;
         mosi_q <= 2'h0;
      end
      else
      begin
         sclk_q <= {sclk_q[1:0], sclk};
         cs_q   <= {cs_q[0], cs_n};
         mosi_q <= {mosi_q[0], mosi};
      end
   end

   // =========================================================
   // state registers
   logic [6:0]       shift_q;
   logic [2:0]       bit_cnt_q;
   logic [2:0]       byte_cnt_q;
   logic [7:0]       opcode_q;
   logic [23:0]      hdr_q;
   logic [11:0]      col_q;
   logic             ecc_en_q;
   logic             otp_en_q;
   logic             lock_req_q;
   logic             lock_q;
   logic             boot_q;
   logic             wel_q;
   logic             fail_q;
   logic [3:0]       ecs_q;
   logic [2:0]       next_page_q;
   logic             link_en_q;

   // =========================================================
   // serial framing and command events
   wire              sclk_rise  = sclk_q[1] & ~sclk_q[2];
   wire              frame      = ~cs_q[1] & link_en_q;
   wire [7:0]        byte_in    = {shift_q, mosi_q[1]};
   wire              byte_done  = frame & sclk_rise & (bit_cnt_q == 3'h7);
   wire              at_b0      = byte_done & (byte_cnt_q == 3'h0);
   wire              at_b2      = byte_done & (byte_cnt_q == 3'h2);
   wire              at_b3      = byte_done & (byte_cnt_q == 3'h3);
   wire [23:0]       row_full   = {hdr_q[15:0], byte_in};
   wire [ROW_W-1:0]  row        = row_full[ROW_W-1:0];
   wire              is_load    = (opcode_q == OP_PROG_LOAD) ||
                                  (opcode_q == OP_LOAD_RAND);

   wire              ev_wren    = at_b0 & (byte_in == OP_WREN);
   wire              ev_wrdi    = at_b0 & (byte_in == OP_WRDI);
   wire              ev_reset   = at_b0 & (byte_in == OP_RESET);
   wire              ev_setf    = at_b2 & (opcode_q == OP_SET_FEAT) &
                                  (hdr_q[7:0] == FEAT_ADDR_OTP);
   wire              ev_pe      = at_b3 & (opcode_q == OP_PROG_EXEC);
   wire              ev_read    = at_b3 & (opcode_q == OP_PAGE_READ);
   wire              ev_col     = at_b2 & is_load;
   wire              ev_data    = byte_done & is_load &
                                  (byte_cnt_q >= 3'h3);

   // =========================================================
   // program decisions
   wire              pe_armed   = ev_pe & wel_q;
   wire              pe_lock    = pe_armed & otp_en_q & lock_req_q;
   wire              pe_otp     = pe_armed & otp_en_q & ~lock_req_q;
   wire              pe_norm    = pe_armed & ~otp_en_q;
   wire              otp_bad    = lock_q |
                                  (row_full >= {21'h0, OTP_PAGES}) |
                                  (row_full != {21'h0, next_page_q});
   wire              otp_prog   = pe_otp & ~otp_bad;
   wire              prog_go    = pe_norm | otp_prog;
   wire              fail_d     = (pe_otp & otp_bad) | (pe_lock & lock_q);
   wire              load_drop  = ecc_en_q & is_parity(col_q);
   wire [3:0]        ecs_done   = (ecc_uncorrectable ||
                                   (ecc_err_bits > ECC_MAX_BITS)) ?
                                  ECC_UNCORR : ecc_err_bits;

   // =========================================================
   // apb decode
   wire              apb_setup  = psel & ~penable;
   wire              apb_wr     = psel & penable & pwrite & pready;
   wire              hit_feat   = (paddr == FEAT_OFF);
   wire              hit_stat   = (paddr == STAT_OFF);
   wire              hit_info   = (paddr == INFO_OFF);
   wire              hit_ctrl   = (paddr == CTRL_OFF);
   wire              hit_geom   = (paddr == GEOM_OFF);
   wire              hit_any    = hit_feat | hit_stat | hit_info |
                                  hit_ctrl | hit_geom;
   wire              wr_feat    = apb_wr & hit_feat;
   wire              wr_ctrl    = apb_wr & hit_ctrl;
   wire [7:0]        feat_word  = {(lock_req_q | lock_q), otp_en_q, 1'b0,
                                   ecc_en_q, 4'h0};
   wire [31:0]       stat_word  = {21'h0, next_page_q, 1'b0, lock_q,
                                   fail_q, wel_q, ecs_q};
   wire [31:0]       info_word  = {5'h0, TOTAL_BLOCKS, 5'h0, MIN_VALID};
   wire [31:0]       geom_word  = {BAD_MARK[3:0], BAD_MARK_COL, 1'b0,
                                   OTP_PAGES, PAGE_BYTES};
   wire [31:0]       rd_word    = hit_feat ? {24'h0, feat_word} :
                                  hit_stat ? stat_word :
                                  hit_info ? info_word :
                                  hit_ctrl ? {31'h0, link_en_q} :
                                  hit_geom ? geom_word : 32'h0;

   // =========================================================
   // serial shifter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         shift_q    <= 7'h0;
         bit_cnt_q  <= 3'h0;
         byte_cnt_q <= 3'h0;
         opcode_q   <= 8'h0;
         hdr_q      <= 24'h0;
      end
      else if (!frame)
      begin
         bit_cnt_q  <= 3'h0;
         byte_cnt_q <= 3'h0;
      end
      else if (sclk_rise)
      begin
         shift_q   <= byte_in[6:0];
         bit_cnt_q <= bit_cnt_q + 3'h1;
         if (byte_done)
         begin
            hdr_q <= row_full;
            if (byte_cnt_q == 3'h0)
               opcode_q <= byte_in;
            if (byte_cnt_q != 3'h4)
               byte_cnt_q <= byte_cnt_q + 3'h1;
         end
      end
   end

   // =========================================================
   // feature bits and otp lock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ecc_en_q    <= ECC_EN_RST;
         otp_en_q    <= OTP_EN_RST;
         lock_req_q  <= LOCK_RST;
         lock_q      <= LOCK_RST;
         boot_q      <= 1'b0;
         next_page_q <= 3'h0;
      end
      else
      begin
         boot_q <= 1'b1;
         if (ev_setf)
         begin
            ecc_en_q   <= byte_in[FEAT_ECC_BIT];
            otp_en_q   <= byte_in[FEAT_EN_BIT];
            lock_req_q <= byte_in[FEAT_LOCK_BIT];
         end
         else if (wr_feat)
         begin
            ecc_en_q   <= pwdata[FEAT_ECC_BIT];
            otp_en_q   <= pwdata[FEAT_EN_BIT];
            lock_req_q <= pwdata[FEAT_LOCK_BIT];
         end
         if (!boot_q)
            lock_q <= otp_lock_nv;
         else if (pe_lock)
            lock_q <= 1'b1;
         if (otp_prog)
            next_page_q <= next_page_q + 3'h1;
      end
   end

   // =========================================================
   // write latch, fail flag and correction status
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wel_q     <= 1'b0;
         fail_q    <= 1'b0;
         ecs_q     <= ECC_NONE;
         link_en_q <= LINK_EN_RST;
      end
      else
      begin
         if (ev_wren)
            wel_q <= 1'b1;
         else if (ev_wrdi || ev_reset || ev_pe)
            wel_q <= 1'b0;
         if (ev_pe)
            fail_q <= fail_d;
         else if (ev_reset)
            fail_q <= 1'b0;
         if (ecc_done && ecc_en_q)
            ecs_q <= ecs_done;
         else if (ev_read || ev_reset)
            ecs_q <= ECC_NONE;
         if (wr_ctrl)
            link_en_q <= pwdata[0];
      end
   end

   // =========================================================
   // array and correction requests
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         array_read     <= 1'b0;
         array_program  <= 1'b0;
         array_otp_sel  <= 1'b0;
         array_row      <= '0;
         ecc_encode     <= 1'b0;
         ecc_decode     <= 1'b0;
         otp_lock_burn  <= 1'b0;
         load_valid     <= 1'b0;
         load_col       <= 12'h0;
         load_data      <= 8'h0;
         load_protected <= 1'b0;
      end
      else
      begin
         array_read    <= ev_read;
         array_program <= prog_go;
         ecc_encode    <= prog_go & ecc_en_q;
         ecc_decode    <= ev_read & ecc_en_q;
         otp_lock_burn <= pe_lock & ~lock_q;
         array_otp_sel <= otp_en_q;
         if (ev_read || prog_go)
            array_row <= row;
         load_valid <= ev_data & ~load_drop;
         if (ev_data)
         begin
            load_col       <= col_q;
            load_data      <= byte_in;
            load_protected <= ecc_en_q & is_covered(col_q);
         end
      end
   end

   // =========================================================
   // column pointer for loaded data
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         col_q <= 12'h0;
      else if (ev_col)
         col_q <= {hdr_q[3:0], byte_in};
      else if (ev_data)
         col_q <= col_q + 12'h1;
   end

   // =========================================================
   // apb slave
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= 1'b1;
         if (apb_setup)
         begin
            prdata  <= rd_word;
            pslverr <= ~hit_any;
         end
      end
   end

endmodule

// >>> verif/nand_otp_ecc_sva.sv
// port checker for the otp and correction control block
`timescale 1ns/1ps
module nand_otp_ecc_sva
   import nand_otp_ecc_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [31:0]       prdata,
   input wire logic              otp_lock_nv,
   input wire logic              array_read,
   input wire logic              array_program,
   input wire logic              array_otp_sel,
   input wire logic              ecc_encode,
   input wire logic              ecc_decode,
   input wire logic              otp_lock_burn,
   input wire logic              load_valid,
   input wire logic [11:0]       load_col,
   input wire logic              load_protected
);
   // =========================================================
   // helper state
   logic nv_q;
   logic first_q;
   logic burned_q;
   wire  setup_rd = psel && !penable && !pwrite;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         nv_q     <= 1'b0;
         first_q  <= 1'b1;
         burned_q <= 1'b0;
      end
      else
      begin
         first_q <= 1'b0;
         if (first_q)
            nv_q <= otp_lock_nv;
         if (otp_lock_burn)
            burned_q <= 1'b1;
      end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // =========================================================
   // assertions
   AST_DEC_PAIR: assert property (ecc_decode |-> array_read)
      else $error("decode pulse without page read");
   AST_ENC_PAIR: assert property (ecc_encode |-> array_program)
      else $error("encode pulse without program");
   AST_READ_PULSE: assert property (array_read |=> !array_read)
      else $error("page read pulse too long");
   AST_BURN_ONCE: assert property (otp_lock_burn |-> !burned_q && !nv_q)
      else $error("lock burned twice");
   AST_OTP_RO: assert property (array_program && array_otp_sel
      && !otp_lock_burn |-> !burned_q && !nv_q)
      else $error("otp programmed while locked");
   AST_PARITY: assert property (load_valid && load_col inside
      {[PARITY_START:PARITY_END]} |-> !load_protected)
      else $error("parity byte load marked protected");
   AST_COVERED: assert property (load_valid && load_protected
      |-> load_col <= META_END)
      else $error("protected flag outside covered range");
   AST_TAIL: assert property (load_valid && load_col > PARITY_END
      |-> !load_protected)
      else $error("tail byte marked protected");
   AST_GEOM: assert property (setup_rd && paddr == GEOM_OFF
      |=> prdata == {4'h0, BAD_MARK_COL, 1'b0, OTP_PAGES, PAGE_BYTES})
      else $error("geometry word wrong");
   AST_INFO: assert property (setup_rd && paddr == INFO_OFF
      |=> prdata == {5'h0, TOTAL_BLOCKS, 5'h0, MIN_VALID})
      else $error("block count word wrong");
   COV_READ: cover property (array_read && ecc_decode);
   COV_PROG: cover property (array_program && array_otp_sel);
   COV_BURN: cover property (otp_lock_burn);
   COV_LOAD: cover property (load_valid && load_protected);
endmodule
bind nand_otp_ecc_ctrl nand_otp_ecc_sva nand_otp_ecc_sva_inst
(
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata),
   .otp_lock_nv(otp_lock_nv), .array_read(array_read),
   .array_program(array_program), .array_otp_sel(array_otp_sel),
   .ecc_encode(ecc_encode), .ecc_decode(ecc_decode),
   .otp_lock_burn(otp_lock_burn), .load_valid(load_valid),
   .load_col(load_col), .load_protected(load_protected)
);

// >>> verif/nand_host_model.sv
// host controller model driving the serial link
`timescale 1ns/1ps
module nand_host_model
(
   output logic sclk,
   output logic cs_n,
   output logic mosi
);
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b1;
   end
   // one frame of n bytes, msb first; clock idles low between frames
   task automatic send(input logic [31:0] w, input int n);
      int i;
      cs_n = 1'b0;
      #40;
      for (i = n * 8 - 1; i >= 0; i--)
      begin
         mosi = w[i];
         #62.5;
         sclk = 1'b1;
         #62.5;
         sclk = 1'b0;
      end
      #20;
      cs_n = 1'b1;
      mosi = ~mosi;
      #300;
   endtask
endmodule

// >>> verif/nand_otp_and_ecc_control_tb_top.sv
// self-checking bench for the otp and correction control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module nand_otp_and_ecc_control_tb_top
   import nand_otp_ecc_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, otp_lock_nv = 1'b0, ecc_done = 1'b0;
   logic ecc_uncorrectable = 1'b0, pready, pslverr, sclk, cs_n, mosi;
   logic [11:0] paddr = 12'h000, load_col;
   logic [31:0] pwdata = 32'h0, prdata, seed = 32'he491, r;
   logic [3:0] ecc_err_bits = 4'h0, eb;
   logic array_read, array_program, array_otp_sel, ecc_encode, ecc_decode;
   logic otp_lock_burn, load_valid, load_protected;
   logic [7:0] array_row, load_data;
   logic [32:0] apb_q[$];
   logic [27:0] ev_q[$];
   logic [32:0] exp_a;
   logic [27:0] exp_e;
   int error_cnt = 0, n_tests = 0, i;
   logic [11:0] cols [4] = '{12'h1ff, 12'h83f, 12'h840, 12'h87a};
   wire [27:0] evsig = otp_lock_burn ? 28'h2000000 : load_valid ?
      {7'h10, load_protected, load_col, load_data} : {array_read,
      array_program, 2'b0, array_otp_sel, ecc_encode | ecc_decode, 14'h0,
      array_row};
   always #5 pclk = ~pclk;
   nand_host_model nand_host_model_inst (.sclk(sclk), .cs_n(cs_n),
      .mosi(mosi));
   nand_otp_ecc_ctrl #(.ROW_W(8)) nand_otp_ecc_ctrl_inst (.pclk(pclk),
      .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .otp_lock_nv(otp_lock_nv), .ecc_done(ecc_done),
      .ecc_err_bits(ecc_err_bits), .ecc_uncorrectable(ecc_uncorrectable),
      .array_read(array_read), .array_program(array_program),
      .array_otp_sel(array_otp_sel), .array_row(array_row),
      .ecc_encode(ecc_encode), .ecc_decode(ecc_decode),
      .otp_lock_burn(otp_lock_burn), .load_valid(load_valid),
      .load_col(load_col), .load_data(load_data),
      .load_protected(load_protected));
   // =========================================================
   // helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic final_report();
      $display("tests %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         error_cnt++;
         final_report();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      apb_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic frm(input logic [31:0] w, input int n);
      nand_host_model_inst.send(w, n);
      repeat (10) @(posedge pclk);
   endtask
   task automatic done(input logic [3:0] b, input logic u);
      ecc_err_bits <= b;
      ecc_uncorrectable <= u;
      ecc_done <= 1'b1;
      @(posedge pclk);
      ecc_done <= 1'b0;
      @(posedge pclk);
   endtask
   // =========================================================
   // monitors
   always @(posedge pclk)
      if (psel && penable && pready && !pwrite)
      begin
         exp_a = apb_q.size() ? apb_q.pop_front() : 33'h0;
         `CHK("apb read", exp_a, {pslverr, prdata})
      end
   always @(posedge pclk)
      if (presetn && (array_read | array_program | otp_lock_burn |
          load_valid))
      begin
         exp_e = ev_q.size() ? ev_q.pop_front() : 28'hfffffff;
         `CHK("event", exp_e, evsig)
      end
   initial
   begin
      repeat (60000) @(posedge pclk);
      error_cnt++;
      final_report();
   end
   // =========================================================
   // main sequence
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(FEAT_OFF, 33'h10);
      rd(INFO_OFF, {6'h0, TOTAL_BLOCKS, 5'h0, MIN_VALID});
      rd(GEOM_OFF, {5'h0, BAD_MARK_COL, 1'b0, OTP_PAGES, PAGE_BYTES});
      rd(12'h020, {1'b1, 32'h0});
      r = rnd();
      apb(1'b1, CTRL_OFF, {r[31:1], 1'b0});
      rd(CTRL_OFF, 33'h0);
      frm(32'h06, 1);
      apb(1'b1, CTRL_OFF, r | 32'h1);
      rd(CTRL_OFF, 33'h1);
      rd(STAT_OFF, 33'h0);
      $display("test reset values done");
      for (i = 0; i < 4; i++)
      begin
         r = rnd();
         eb = r[11:8];
         ev_q.push_back({4'h8, 1'b0, i < 3, 14'h0, r[7:0]});
         if (i == 3)
            apb(1'b1, FEAT_OFF, r & 32'hffffff2f);
         frm({8'h13, 16'h0, r[7:0]}, 4);
         done(eb, i == 2);
         rd(STAT_OFF, i == 3 ? 33'h0 : (i == 2 || eb > 4'h8) ? 33'hf :
            33'(eb));
      end
      $display("test correction status done");
      frm(32'h1fb050, 3);
      rd(FEAT_OFF, 33'h50);
      ev_q.push_back(28'h4c00000);
      frm(32'h06, 1);
      frm(32'h10000000, 4);
      frm(32'h06, 1);
      frm(32'h10000002, 4);
      rd(STAT_OFF, 33'h120);
      ev_q.push_back(28'h4c00001);
      frm(32'h06, 1);
      frm(32'h10000001, 4);
      for (i = 0; i < 4; i++)
      begin
         r = rnd();
         if (i != 2)
            ev_q.push_back({7'h10, i < 2, cols[i], r[7:0]});
         frm({8'h02, 4'h0, cols[i], r[7:0]}, 4);
      end
      $display("test otp program done");
      ev_q.push_back(28'h2000000);
      frm(32'h1fb0d0, 3);
      frm(32'h06, 1);
      frm(32'h10000000, 4);
      rd(STAT_OFF, 33'h240);
      for (i = 0; i < 2; i++)
      begin
         frm(32'h06, 1);
         frm(32'h10000002, 4);
      end
      rd(STAT_OFF, 33'h260);
      $display("test lock done");
      otp_lock_nv <= 1'b1;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(FEAT_OFF, 33'h90);
      frm(32'h1fb050, 3);
      frm(32'h06, 1);
      frm(32'h10000000, 4);
      ev_q.push_back(28'h8c00000);
      frm(32'h13000000, 4);
      frm(32'h1fb010, 3);
      ev_q.push_back(28'h4400005);
      frm(32'h06, 1);
      frm(32'h10000005, 4);
      $display("test power-on lock done");
      `CHK("pending", 32'h0, 32'(ev_q.size() + apb_q.size()))
      final_report();
   end
endmodule
